// >>> logic/ipd_pkg.sv
// Constants, state and carrier types for the idle and power-down controller
package ipd_pkg;

  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam logic [7:0] PWR_CTRL_ADDR    = 8'h87;
  localparam int         GF_ONE_BIT       = 3;
  localparam int         GF_ZERO_BIT      = 2;
  localparam int         PD_REQ_BIT       = 1;
  localparam int         IDLE_REQ_BIT     = 0;
  localparam logic [3:0] PWR_CTRL_RST     = 4'h0;
  localparam logic [3:0] RSVD_READ_VAL    = 4'h0;
  localparam logic [7:0] UNMAPPED_READ    = 8'h00;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int         CLK_PERIOD_PS    = 5000;
  localparam int         RST_WAKE_NS      = 100;
  localparam int         RST_WAKE_CYC     = (RST_WAKE_NS * 1000 + CLK_PERIOD_PS - 1)
                                            / CLK_PERIOD_PS;
  localparam int         TMR_W            = 8;
  localparam logic [TMR_W-1:0] TMR_LOAD   = TMR_W'(RST_WAKE_CYC - 1);
  localparam logic [TMR_W-1:0] TMR_ZERO   = 8'h00;
  localparam logic [TMR_W-1:0] TMR_ONE    = 8'h01;

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_RUN      = 3'b000,
    ST_IDLE     = 3'b001,
    ST_PDOWN    = 3'b010,
    ST_PD_HOLD  = 3'b011,
    ST_RST_WAKE = 3'b100
  } ipd_state_type;

  typedef struct packed {
    logic osc_en;
    logic periph_en;
    logic cpu_en;
  } ipd_clk_ctl_type;

  localparam ipd_clk_ctl_type CLK_ALL_ON  = 3'b111;
  localparam ipd_clk_ctl_type CLK_CPU_OFF = 3'b110;
  localparam ipd_clk_ctl_type CLK_ALL_OFF = 3'b000;

endpackage

// >>> logic/ipd_wake_timer.sv
// Down-counter that times the run-on window after a reset-pin wake
`timescale 1ns/1ps
module ipd_wake_timer
  import ipd_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic start_i,
  output logic      done_o
);

  logic [TMR_W-1:0] cnt_r;
  logic             busy_r;

  // ---------------------------------------------------------------------------
  // Counter
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r  <= TMR_ZERO;
      busy_r <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (start_i) begin
        cnt_r  <= TMR_LOAD;
        busy_r <= 1'b1;
      end else if (busy_r) begin
        // End one count early so the fenced window spans exactly the load plus one
        if (cnt_r == TMR_ONE) begin
          busy_r <= 1'b0;
          done_o <= 1'b1;
        end else begin
          cnt_r <= cnt_r - TMR_ONE;
        end
      end
    end
  end

endmodule // ipd_wake_timer

// >>> logic/ipd_idle_powerdown_ctrl.sv
// Idle and power-down sequencer with its power control register
`timescale 1ns/1ps

// Functional notes
// R1: Idle stops CPU clock, halts execution, peripherals and interrupts keep clocking.
// R2: Idle keeps program counter, status word, special registers and RAM unchanged.
// R3: Idle starts right after the instruction that sets the idle request bit.
// R4: Both request bits set together give power-down only, never idle afterwards.
// R5: Enabled interrupt in idle clears idle request bit and restores CPU clock.
// R6: Two general flags are freely read and written and kept across idle.
// R7: Reset pin high in idle clears idle bit asynchronously, restores CPU clock.
// R8: During run-on after reset wake, internal RAM is blocked, ports stay usable.
// R9: Software should not write ports or external RAM right after idle entry.
// R10: Power-down stops oscillator and all clocks, keeping all state.
// R11: Power-down starts right after the instruction setting the power-down bit.
// R12: Enabled external pin interrupt clears power-down bit and restarts all clocks; here the CPU clock stays off in ST_PD_HOLD until the pin is released.
// R13: After external wake, execution waits until the interrupt pin is released.
// R14: Wake interrupt must be level-triggered, top priority, held for oscillator start.
// R15: External-interrupt wake leaves special registers and RAM unchanged.
// R16: Reset pin high in power-down clears power-down bit asynchronously, restarts clocks.
// R17: Reset wake from power-down resets special registers but keeps RAM.
// R18: Software should not write ports or external RAM right after power-down entry.
// R19: Register bits: flag one 3, flag zero 2, power-down 1, idle 0.
// R20: Reset clears the four defined register bits.
// R21: Power-down ignores every wake source except the two external pins and reset.
module ipd_idle_powerdown_ctrl
  import ipd_pkg::*;
(
  input  wire logic              REF_CLK_I,
  input  wire logic              SYS_RST_I,
  input  wire logic              RST_PIN_I,
  input  wire logic [7:0]        REG_ADDR_I,
  input  wire logic [7:0]        REG_WDATA_I,
  input  wire logic              REG_WR_I,
  input  wire logic              REG_RD_I,
  input  wire logic              IRQ_PENDING_I,
  input  wire logic              EXT_IRQ_PIN_A_N_I,
  input  wire logic              EXT_IRQ_PIN_B_N_I,
  input  wire logic [1:0]        EXT_IRQ_EN_I,
  output logic [7:0]             REG_RDATA_O,
  output ipd_pkg::ipd_clk_ctl_type CLK_CTL_O,
  output logic                   RAM_BLOCK_O,
  output logic                   CORE_RST_O,
  output ipd_pkg::ipd_state_type STATE_O
);
  import ipd_pkg::*;

  // ---------------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------------
  ipd_state_type   state_r;
  ipd_state_type   state_nxt;
  ipd_clk_ctl_type clk_nxt;
  logic            idle_request_bit_r;
  logic            powerdown_request_bit_r;
  logic            general_flag_one_r;
  logic            general_flag_zero_r;
  logic            pin_meta_r;
  logic            pin_sync_r;
  logic            wr_hit;
  logic            rd_hit;
  logic            ext_wake;
  logic            idle_wake;
  logic            timer_start;
  logic            timer_done;
  logic [3:0]      pwr_ctrl_val;

  assign wr_hit   = REG_WR_I && (REG_ADDR_I == PWR_CTRL_ADDR) && (state_r == ST_RUN);
  assign rd_hit   = REG_RD_I && (REG_ADDR_I == PWR_CTRL_ADDR);
  // Only the two external pins count while every internal clock is frozen
  assign ext_wake = (EXT_IRQ_EN_I[0] && !EXT_IRQ_PIN_A_N_I)
                  || (EXT_IRQ_EN_I[1] && !EXT_IRQ_PIN_B_N_I); // R21
  assign idle_wake = (state_r == ST_IDLE) && IRQ_PENDING_I && !pin_sync_r;

  assign pwr_ctrl_val = {general_flag_one_r, general_flag_zero_r,
                         powerdown_request_bit_r, idle_request_bit_r}; // R19

  // ---------------------------------------------------------------------------
  // Reset pin synchroniser
  // ---------------------------------------------------------------------------
  always_ff @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      pin_meta_r <= 1'b0;
      pin_sync_r <= 1'b0;
    end else begin
      pin_meta_r <= RST_PIN_I;
      pin_sync_r <= pin_meta_r;
    end
  end

  // ---------------------------------------------------------------------------
  // Mode request bits
  // ---------------------------------------------------------------------------
  // The reset pin must clear these even with the oscillator stopped, hence async
  always_ff @(posedge REF_CLK_I or posedge RST_PIN_I) begin
    if (RST_PIN_I) begin
      idle_request_bit_r      <= 1'b0; // R7
      powerdown_request_bit_r <= 1'b0; // R16
    end else if (SYS_RST_I || CORE_RST_O) begin
      idle_request_bit_r      <= PWR_CTRL_RST[IDLE_REQ_BIT]; // R20
      powerdown_request_bit_r <= PWR_CTRL_RST[PD_REQ_BIT];
    end else if (wr_hit) begin
      powerdown_request_bit_r <= REG_WDATA_I[PD_REQ_BIT];
      // Power-down wins; idle is dropped so it cannot follow the wake
      idle_request_bit_r      <= REG_WDATA_I[IDLE_REQ_BIT]
                                 && !REG_WDATA_I[PD_REQ_BIT]; // R4
    end else begin
      if (idle_wake) begin
        idle_request_bit_r <= 1'b0; // R5
      end
      if ((state_r == ST_PDOWN) && ext_wake) begin
        powerdown_request_bit_r <= 1'b0; // R12
      end
    end
  end

  // ---------------------------------------------------------------------------
  // General flags
  // ---------------------------------------------------------------------------
  // Writes are only taken in run, so idle and power-down keep the flags
  always_ff @(posedge REF_CLK_I) begin
    if (SYS_RST_I || CORE_RST_O) begin
      general_flag_one_r  <= PWR_CTRL_RST[GF_ONE_BIT]; // R17
      general_flag_zero_r <= PWR_CTRL_RST[GF_ZERO_BIT];
    end else if (wr_hit) begin
      general_flag_one_r  <= REG_WDATA_I[GF_ONE_BIT]; // R6
      general_flag_zero_r <= REG_WDATA_I[GF_ZERO_BIT];
    end
  end

  // ---------------------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------------------
  always_ff @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      REG_RDATA_O <= UNMAPPED_READ;
    end else if (rd_hit) begin
      REG_RDATA_O <= {RSVD_READ_VAL, pwr_ctrl_val};
    end else begin
      REG_RDATA_O <= UNMAPPED_READ;
    end
  end

  // ---------------------------------------------------------------------------
  // Mode sequencer
  // ---------------------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_RUN: begin
        if (wr_hit && REG_WDATA_I[PD_REQ_BIT]) begin
          state_nxt = ST_PDOWN; // R11 R4
        end else if (wr_hit && REG_WDATA_I[IDLE_REQ_BIT]) begin
          state_nxt = ST_IDLE; // R3
        end
      end
      ST_IDLE: begin
        if (pin_sync_r) begin
          state_nxt = ST_RST_WAKE; // R7
        end else if (IRQ_PENDING_I) begin
          state_nxt = ST_RUN; // R5
        end
      end
      ST_PDOWN: begin
        if (pin_sync_r) begin
          state_nxt = ST_RST_WAKE; // R16
        end else if (ext_wake) begin
          state_nxt = ST_PD_HOLD; // R12 R15
        end
      end
      ST_PD_HOLD: begin
        if (pin_sync_r) begin
          state_nxt = ST_RST_WAKE;
        end else if (!ext_wake) begin
          state_nxt = ST_RUN; // R13
        end
      end
      ST_RST_WAKE: begin
        if (timer_done) begin
          state_nxt = ST_RUN;
        end
      end
      default: begin
        state_nxt = ST_RUN;
      end
    endcase
  end

  always_comb begin
    case (state_nxt)
      ST_RUN:      clk_nxt = CLK_ALL_ON;
      ST_IDLE:     clk_nxt = CLK_CPU_OFF; // R1 R2
      ST_PDOWN:    clk_nxt = CLK_ALL_OFF; // R10
      ST_PD_HOLD:  clk_nxt = CLK_CPU_OFF; // R13
      ST_RST_WAKE: clk_nxt = CLK_ALL_ON;
      default:     clk_nxt = CLK_ALL_ON;
    endcase
  end

  assign timer_start = (state_r != ST_RST_WAKE) && (state_nxt == ST_RST_WAKE);

  always_ff @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      state_r   <= ST_RUN;
      STATE_O   <= ST_RUN;
      CLK_CTL_O <= CLK_ALL_ON;
    end else begin
      state_r   <= state_nxt;
      STATE_O   <= state_nxt;
      CLK_CTL_O <= clk_nxt;
    end
  end

  // ---------------------------------------------------------------------------
  // Reset-wake run-on window
  // ---------------------------------------------------------------------------
  // The CPU runs on a few cycles before its reset; RAM is fenced off meanwhile
  always_ff @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      RAM_BLOCK_O <= 1'b0;
      CORE_RST_O  <= 1'b0;
    end else begin
      RAM_BLOCK_O <= (state_nxt == ST_RST_WAKE); // R8
      CORE_RST_O  <= (state_r == ST_RST_WAKE) && timer_done; // R17
    end
  end

  ipd_wake_timer u_wake_timer (
    .clk_i   (REF_CLK_I),
    .rst_i   (SYS_RST_I),
    .start_i (timer_start),
    .done_o  (timer_done)
  );

endmodule // ipd_idle_powerdown_ctrl

// >>> tb/ipd_ctrl_properties.sv
// Concurrent checks for the idle and power-down controller
`timescale 1ns/1ps
module ipd_ctrl_properties
  import ipd_pkg::*;
(
  input wire logic                     REF_CLK_I,
  input wire logic                     SYS_RST_I,
  input wire logic                     RST_PIN_I,
  input wire logic [7:0]               REG_ADDR_I,
  input wire logic [7:0]               REG_WDATA_I,
  input wire logic                     REG_WR_I,
  input wire logic                     REG_RD_I,
  input wire logic                     IRQ_PENDING_I,
  input wire logic                     EXT_IRQ_PIN_A_N_I,
  input wire logic                     EXT_IRQ_PIN_B_N_I,
  input wire logic [1:0]               EXT_IRQ_EN_I,
  input wire logic [7:0]               REG_RDATA_O,
  input wire ipd_pkg::ipd_clk_ctl_type CLK_CTL_O,
  input wire logic                     RAM_BLOCK_O,
  input wire logic                     CORE_RST_O,
  input wire ipd_pkg::ipd_state_type   STATE_O
);
  // ----------
  // Helpers
  // ----------
  logic [2:0] pin_h_r;
  logic [7:0] blk_cnt_r;
  logic       wake_ext;
  logic       quiet;
  logic       wr_ok;
  assign wake_ext = (EXT_IRQ_EN_I[0] & ~EXT_IRQ_PIN_A_N_I) | (EXT_IRQ_EN_I[1] & ~EXT_IRQ_PIN_B_N_I);
  // Pin reset passes a synchroniser, so its recent history must be quiet too
  assign quiet = ~RST_PIN_I & ~|pin_h_r;
  assign wr_ok = REG_WR_I & (REG_ADDR_I == PWR_CTRL_ADDR) & (STATE_O == ST_RUN) & quiet;
  always_ff @(posedge REF_CLK_I) begin
    pin_h_r <= SYS_RST_I ? 3'h0 : {pin_h_r[1:0], RST_PIN_I};
  end
  always_ff @(posedge REF_CLK_I) begin
    blk_cnt_r <= RAM_BLOCK_O ? blk_cnt_r + 8'h01 : 8'h00;
  end
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (SYS_RST_I);
  sequence run_on_seq;
    (STATE_O == ST_RST_WAKE) && RAM_BLOCK_O;
  endsequence
  sequence core_rst_seq;
    CORE_RST_O && (STATE_O == ST_RUN) ##1 !CORE_RST_O;
  endsequence
  rd_quiet_a: assert property (!$past(REG_RD_I) |-> REG_RDATA_O == 8'h00)
    else $error("read data not zero outside answer cycle");
  idle_entry_a: assert property (wr_ok && REG_WDATA_I[1:0] == 2'b01 |=>
    STATE_O == ST_IDLE && CLK_CTL_O == CLK_CPU_OFF) else $error("idle entry wrong");
  pd_entry_a: assert property (wr_ok && REG_WDATA_I[PD_REQ_BIT] |=>
    STATE_O == ST_PDOWN && CLK_CTL_O == CLK_ALL_OFF) else $error("power-down entry wrong");
  idle_wake_a: assert property (STATE_O == ST_IDLE && IRQ_PENDING_I && quiet |=>
    STATE_O == ST_RUN && CLK_CTL_O == CLK_ALL_ON) else $error("idle wake wrong");
  pd_ignore_a: assert property (STATE_O == ST_PDOWN && !wake_ext && quiet |=>
    STATE_O == ST_PDOWN) else $error("power-down left without pin wake");
  pd_wake_a: assert property (STATE_O == ST_PDOWN && wake_ext && quiet |=>
    STATE_O == ST_PD_HOLD && CLK_CTL_O == CLK_CPU_OFF) else $error("pin wake wrong");
  hold_release_a: assert property (STATE_O == ST_PD_HOLD && quiet |=>
    STATE_O == ($past(wake_ext) ? ST_PD_HOLD : ST_RUN)) else $error("hold release wrong");
  rst_wake_a: assert property ($rose(RST_PIN_I) && STATE_O inside {ST_IDLE, ST_PDOWN}
    |-> ##3 run_on_seq) else $error("pin reset wake wrong");
  run_on_end_a: assert property ($fell(RAM_BLOCK_O) |->
    (blk_cnt_r == 8'(RST_WAKE_CYC)) ##0 core_rst_seq) else $error("run-on window wrong");
endmodule // ipd_ctrl_properties

bind ipd_idle_powerdown_ctrl ipd_ctrl_properties u_props (
  .REF_CLK_I(REF_CLK_I), .SYS_RST_I(SYS_RST_I), .RST_PIN_I(RST_PIN_I),
  .REG_ADDR_I(REG_ADDR_I), .REG_WDATA_I(REG_WDATA_I), .REG_WR_I(REG_WR_I),
  .REG_RD_I(REG_RD_I), .IRQ_PENDING_I(IRQ_PENDING_I), .EXT_IRQ_EN_I(EXT_IRQ_EN_I),
  .EXT_IRQ_PIN_A_N_I(EXT_IRQ_PIN_A_N_I), .EXT_IRQ_PIN_B_N_I(EXT_IRQ_PIN_B_N_I),
  .REG_RDATA_O(REG_RDATA_O), .CLK_CTL_O(CLK_CTL_O), .RAM_BLOCK_O(RAM_BLOCK_O),
  .CORE_RST_O(CORE_RST_O), .STATE_O(STATE_O));

// >>> tb/ipd_wake_src.sv
// External interrupt pin model: held low for a set number of cycles
`timescale 1ns/1ps
module ipd_wake_src (
  input  wire logic       clk_i,
  input  wire logic       go_i,
  input  wire logic [7:0] len_i,
  output logic            pin_n_o
);
  logic [7:0] cnt_r = 8'h00;
  // Level wake, held long enough for the oscillator to settle
  always_ff @(posedge clk_i) begin
    if (go_i) cnt_r <= len_i;
    else if (cnt_r != 8'h00) cnt_r <= cnt_r - 8'h01;
  end
  assign pin_n_o = (cnt_r == 8'h00);
endmodule // ipd_wake_src

// >>> tb/tb.sv
// Self-checking bench for the idle and power-down controller
`timescale 1ns/1ps
module tb;
  import ipd_pkg::*;
  logic            clk = 1'b0;
  logic            rst = 1'b1;
  logic            pin_rst = 1'b0;
  logic [7:0]      addr = 8'h00;
  logic [7:0]      wdat = 8'h00;
  logic            wr = 1'b0;
  logic            rd = 1'b0;
  logic            irq = 1'b0;
  logic [1:0]      en = 2'b00;
  logic [1:0]      go = 2'b00;
  logic [1:0]      pin_n;
  logic [7:0]      rdat;
  logic [7:0]      v;
  logic [15:0]     lf = 16'ha115;
  logic            ram_blk;
  logic            core_rst;
  ipd_clk_ctl_type clk_ctl;
  ipd_state_type   st;
  int              bad_count = 0;
  int              num_checks = 0;
  int              mreg = 0;
  always #2.5 clk = ~clk;
  ipd_idle_powerdown_ctrl dut (.REF_CLK_I(clk), .SYS_RST_I(rst), .RST_PIN_I(pin_rst),
    .REG_ADDR_I(addr), .REG_WDATA_I(wdat), .REG_WR_I(wr), .REG_RD_I(rd),
    .IRQ_PENDING_I(irq), .EXT_IRQ_PIN_A_N_I(pin_n[0]), .EXT_IRQ_PIN_B_N_I(pin_n[1]),
    .EXT_IRQ_EN_I(en), .REG_RDATA_O(rdat), .CLK_CTL_O(clk_ctl), .RAM_BLOCK_O(ram_blk),
    .CORE_RST_O(core_rst), .STATE_O(st));
  ipd_wake_src u_src_a (.clk_i(clk), .go_i(go[0]), .len_i(8'h1e), .pin_n_o(pin_n[0]));
  ipd_wake_src u_src_b (.clk_i(clk), .go_i(go[1]), .len_i(8'h1e), .pin_n_o(pin_n[1]));
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic wrr(input logic [7:0] d);
    @(posedge clk);
    addr <= PWR_CTRL_ADDR;
    wdat <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rdr(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdat;
  endtask
  task automatic wait_st(input ipd_state_type s);
    int n;
    n = 0;
    while (st !== s && n < 200) begin
      @(posedge clk);
      #1 n++;
    end
    if (st !== s) begin
      bad_count++;
      give_verdict();
    end
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rdr(PWR_CTRL_ADDR);
    chk(v, 8'h00);
    rdr(8'h55);
    chk(v, UNMAPPED_READ);
    for (int i = 0; i < 4; i++) begin
      lf = lfsr(lf);
      mreg = {lf[3:2], 2'b00};
      wrr(8'(mreg));
      rdr(PWR_CTRL_ADDR);
      chk(v, 8'(mreg));
    end
    wrr(8'(mreg | 1));
    wait_st(ST_IDLE);
    chk(8'(clk_ctl), 8'(CLK_CPU_OFF));
    rdr(PWR_CTRL_ADDR);
    chk(v, 8'(mreg | 1));
    @(posedge clk);
    irq <= 1'b1;
    wait_st(ST_RUN);
    @(posedge clk);
    irq <= 1'b0;
    rdr(PWR_CTRL_ADDR);
    chk(v, 8'(mreg));
    for (int p = 0; p < 2; p++) begin
      @(posedge clk);
      en <= 2'(1 << p);
      wrr(8'(mreg | 3 - p));
      wait_st(ST_PDOWN);
      @(posedge clk);
      irq <= 1'b1;
      go <= 2'(2 >> p);
      @(posedge clk);
      go <= 2'b00;
      repeat (8) @(posedge clk);
      #1 chk(8'(st), 8'(ST_PDOWN));
      @(posedge clk);
      irq <= 1'b0;
      go <= 2'(1 << p);
      @(posedge clk);
      go <= 2'b00;
      wait_st(ST_PD_HOLD);
      chk(8'(clk_ctl), 8'(CLK_CPU_OFF));
      wait_st(ST_RUN);
      rdr(PWR_CTRL_ADDR);
      chk(v, 8'(mreg));
    end
    for (int m = 1; m < 3; m++) begin
      wrr(8'(mreg | m));
      wait_st(m == 1 ? ST_IDLE : ST_PDOWN);
      @(posedge clk);
      pin_rst <= 1'b1;
      rdr(PWR_CTRL_ADDR);
      chk(v, 8'(mreg));
      wait_st(ST_RST_WAKE);
      chk(8'(ram_blk), 8'h01);
      @(posedge clk);
      pin_rst <= 1'b0;
      wait_st(ST_RUN);
      rdr(PWR_CTRL_ADDR);
      chk(v, 8'h00);
    end
    wrr(8'h0c);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rdr(PWR_CTRL_ADDR);
    chk(v, PWR_CTRL_RST);
    give_verdict();
  end
endmodule // tb
